/* common/qetl_pkg.sv */
// Package with the register map, field layout and state encoding of the erase timing and lane block.
package qetl_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [31:0] QETL_OPC_ADDR = 32'h0C000028; // Erase related opcode codes.
  localparam logic [31:0] QETL_ETL_ADDR = 32'h0C00002C; // Erase timing and lane control.
  localparam logic [31:0] QETL_BRK_ADDR = 32'h0C000030; // Burst break control.
  localparam logic [31:0] QETL_STS_ADDR = 32'h0C000040; // Sequencer status, read only.

  // Values after reset.
  localparam logic [31:0] QETL_OPC_RST = 32'h00000000;
  localparam logic [31:0] QETL_ETL_RST = 32'h00000000;
  localparam logic [31:0] QETL_BRK_RST = 32'h00000000;

  // Writable bits; all others are reserved, read zero and ignore writes.
  localparam logic [31:0] QETL_OPC_MASK = 32'hFFFFFFFF;
  localparam logic [31:0] QETL_ETL_MASK = 32'h3F0F7FFF;
  localparam logic [31:0] QETL_BRK_MASK = 32'h001FFFFF;

  // Fields of the erase timing and lane control register.
  localparam int QETL_SGD_LSB = 24; // Suspend guard delay, 222 kHz cycles.
  localparam int QETL_SGD_W = 6;
  localparam int QETL_HLD_LSB = 16; // Read idle hold count, bus clock cycles.
  localparam int QETL_HLD_W = 4;
  localparam int QETL_CSH_LSB = 10; // Erase chip select high cycles, flash clock cycles.
  localparam int QETL_CSH_W = 5;
  localparam int QETL_EAD_LSB = 8; // Erase address lane mode.
  localparam int QETL_RES_LSB = 6; // Resume lane mode.
  localparam int QETL_SUS_LSB = 4; // Suspend lane mode.
  localparam int QETL_WEN_LSB = 2; // Write enable lane mode.
  localparam int QETL_ERS_LSB = 0; // Erase opcode lane mode.
  localparam int QETL_LANE_W = 2;

  // Fields of the opcode register.
  localparam int QETL_OPC_ERS_LSB = 0;
  localparam int QETL_OPC_WEN_LSB = 8;
  localparam int QETL_OPC_SUS_LSB = 16;
  localparam int QETL_OPC_RES_LSB = 24;
  localparam int QETL_OPC_W = 8;

  // Fields of the burst break control register.
  localparam int QETL_BRK_WRD_LSB = 0;
  localparam int QETL_BRK_WRD_W = 16;
  localparam int QETL_BRK_EN_BIT = 16;
  localparam int QETL_BRK_SZ_BIT = 17;
  localparam int QETL_BRK_MD_LSB = 18;
  localparam int QETL_SEC_HF_BIT = 20;

  // Lane mode encoding shared by every lane mode field.
  localparam logic [1:0] QETL_LANE_SINGLE = 2'h0;
  localparam logic [1:0] QETL_LANE_DUAL = 2'h1;
  localparam logic [1:0] QETL_LANE_QUAD = 2'h2;

  // Counter reset value.
  localparam logic [5:0] QETL_CNT_RST = 6'h00;

  // Sequencer states, Gray coded in their listed order from idle to resume.
  typedef enum logic [3:0] {
    QETL_IDLE = 4'h0,
    QETL_HOLD = 4'h1,
    QETL_WEN = 4'h3,
    QETL_CSH = 4'h2,
    QETL_ERS = 4'h6,
    QETL_RUN = 4'h7,
    QETL_GUARD = 4'h5,
    QETL_SUS = 4'h4,
    QETL_SUSP = 4'hC,
    QETL_RES = 4'hD
  } qetl_state_t;

endpackage

/* core/qetl_top.sv */
// Erase sequencer timing and lane control with its APB register file.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
//
// Overview of operation
// - Suspend waits guard count of 222 kHz cycles
// - Guard timer restarts after erase or resume
// - Erase or resume waits read idle hold
// - Chip select held high after erase instructions
// - Erase address phase uses its lane mode
// - Erase opcode phase uses its lane mode
// - Resume, suspend, write enable have lane modes
// - Second half tristate releases low nibble lines
// - Tristate only with break enabled, two bytes
// - Opcodes come from programmable code fields
// - Break size picks upper byte or word
// - Break sent auto, once mode, read then other
module qetl_top
  import qetl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic qspi_clk_in,
  input wire logic tick_222k,
  input wire logic erase_req,
  input wire logic suspend_req,
  input wire logic resume_req,
  input wire logic erase_done,
  input wire logic read_pending,
  input wire logic cmd_done,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [1:0] cmd_lane_mode,
  output logic cmd_has_addr,
  output logic [1:0] cmd_addr_lane_mode,
  output logic cs_force_high,
  output logic seq_busy,
  input wire logic auto_mode,
  input wire logic instruction_once_mode,
  input wire logic prev_cmd_read,
  input wire logic next_cmd_nonread,
  output logic brk_request,
  output logic [15:0] break_word,
  output logic break_two_bytes,
  output logic [1:0] break_lane_mode,
  input wire logic io_drive_req,
  input wire logic brk_low_nibble,
  output logic io_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // State of the block.

  // All state lives in one packed record so the register stage stays trivially uniform.
  typedef struct packed {
    qetl_state_t st; // Sequencer state.
    qetl_state_t ret; // State taken after a hold or chip select wait.
    logic [31:0] opc; // Opcode register.
    logic [31:0] etl; // Timing and lane register.
    logic [31:0] brk; // Burst break register.
    logic [31:0] rdata; // Read data captured in the setup cycle.
    logic [5:0] guard_cnt; // 222 kHz ticks since the last erase or resume.
    logic [3:0] hold_cnt; // Bus cycles with no pending read.
    logic [4:0] csh_cnt; // Flash clock edges with chip select held high.
    logic [1:0] qclk_sync; // Synchroniser for the flash clock.
    logic [1:0] tick_sync; // Synchroniser for the 222 kHz clock.
    logic qclk_prev; // Last synchronised flash clock level.
    logic tick_prev; // Last synchronised 222 kHz level.
  } qetl_regs_t;

  qetl_regs_t state_r; // Registered state.
  qetl_regs_t state_nxt; // Next state.
  logic qclk_rise; // One cycle per flash clock rising edge.
  logic tick_rise; // One cycle per 222 kHz rising edge.
  logic wr_en; // APB write in its access phase.
  logic addr_hit; // Address falls on a mapped register.

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Read multiplexer for the register file; unmapped addresses read zero.
  function automatic logic [31:0] rd_mux(input logic [31:0] a, input qetl_regs_t s);
    logic [31:0] d;
    d = 32'h00000000;
    case (a)
      QETL_OPC_ADDR: d = s.opc;
      QETL_ETL_ADDR: d = s.etl;
      QETL_BRK_ADDR: d = s.brk;
      QETL_STS_ADDR: d = {28'h0000000, s.st};
      default: d = 32'h00000000;
    endcase
    return d;
  endfunction

  // Address decode used both for the error answer and for the write strobe.
  function automatic logic is_mapped(input logic [31:0] a);
    return (a == QETL_OPC_ADDR) || (a == QETL_ETL_ADDR) || (a == QETL_BRK_ADDR) || (a == QETL_STS_ADDR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Clock edge detection and bus handshake.

  // Edges come from the second synchroniser stage only, never from the first.
  assign qclk_rise = state_r.qclk_sync[1] & ~state_r.qclk_prev;
  assign tick_rise = state_r.tick_sync[1] & ~state_r.tick_prev;
  assign addr_hit = is_mapped(paddr);
  assign wr_en = psel & penable & pwrite & addr_hit;

  // Zero wait state slave; unmapped addresses answer with an error.
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata = state_r.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state logic.

  // One combinational process computes the whole next state.
  always_comb begin
    state_nxt = state_r;
    state_nxt.qclk_sync = {state_r.qclk_sync[0], qspi_clk_in};
    state_nxt.tick_sync = {state_r.tick_sync[0], tick_222k};
    state_nxt.qclk_prev = state_r.qclk_sync[1];
    state_nxt.tick_prev = state_r.tick_sync[1];

    // Read data is fetched in the setup cycle so it is stable from a flop in the access phase.
    if (psel && !penable && !pwrite) begin
      state_nxt.rdata = rd_mux(paddr, state_r);
    end

    // Register writes keep reserved bits at zero.
    if (wr_en) begin
      case (paddr)
        QETL_OPC_ADDR: state_nxt.opc = pwdata & QETL_OPC_MASK;
        QETL_ETL_ADDR: state_nxt.etl = pwdata & QETL_ETL_MASK;
        QETL_BRK_ADDR: state_nxt.brk = pwdata & QETL_BRK_MASK;
        default: state_nxt.opc = state_r.opc;
      endcase
    end

    // Guard timer saturates so a long erase never wraps into a false short count.
    if (tick_rise && state_r.guard_cnt != 6'h3F) begin
      state_nxt.guard_cnt = state_r.guard_cnt + 6'h01;
    end

    // Idle hold counts bus cycles and restarts on any pending read.
    if (read_pending) begin
      state_nxt.hold_cnt = 4'h0;
    end else if (state_r.hold_cnt != 4'hF) begin
      state_nxt.hold_cnt = state_r.hold_cnt + 4'h1;
    end

    // Chip select high time counts flash clock edges, saturating.
    if (qclk_rise && state_r.csh_cnt != 5'h1F) begin
      state_nxt.csh_cnt = state_r.csh_cnt + 5'h01;
    end

    // Sequencer; requests outside their state are ignored.
    case (state_r.st)
      QETL_IDLE: begin
        if (erase_req) begin
          state_nxt.st = QETL_HOLD;
          state_nxt.ret = QETL_WEN;
          state_nxt.hold_cnt = 4'h0;
        end
      end
      QETL_HOLD: begin
        // Erase and resume both wait for a quiet read path.
        if (!read_pending && state_r.hold_cnt >= state_r.etl[QETL_HLD_LSB +: QETL_HLD_W]) begin
          state_nxt.st = state_r.ret;
        end
      end
      QETL_WEN: begin
        if (cmd_done) begin
          state_nxt.st = QETL_CSH;
          state_nxt.ret = QETL_ERS;
          state_nxt.csh_cnt = 5'h00;
        end
      end
      QETL_ERS, QETL_RES: begin
        if (cmd_done) begin
          state_nxt.st = QETL_CSH;
          state_nxt.ret = QETL_RUN;
          state_nxt.csh_cnt = 5'h00;
          state_nxt.guard_cnt = QETL_CNT_RST;
        end
      end
      QETL_SUS: begin
        if (cmd_done) begin
          state_nxt.st = QETL_CSH;
          state_nxt.ret = QETL_SUSP;
          state_nxt.csh_cnt = 5'h00;
        end
      end
      QETL_CSH: begin
        // Chip select stays high for at least the programmed flash clock cycles.
        if (state_r.csh_cnt >= state_r.etl[QETL_CSH_LSB +: QETL_CSH_W]) begin
          state_nxt.st = state_r.ret;
        end
      end
      QETL_RUN: begin
        if (erase_done) begin
          state_nxt.st = QETL_IDLE;
        end else if (suspend_req) begin
          state_nxt.st = QETL_GUARD;
        end
      end
      QETL_GUARD: begin
        // A zero guard lets the suspend go out at once.
        if (erase_done) begin
          state_nxt.st = QETL_IDLE;
        end else if (state_r.guard_cnt >= state_r.etl[QETL_SGD_LSB +: QETL_SGD_W]) begin
          state_nxt.st = QETL_SUS;
        end
      end
      QETL_SUSP: begin
        if (resume_req) begin
          state_nxt.st = QETL_HOLD;
          state_nxt.ret = QETL_RES;
          state_nxt.hold_cnt = 4'h0;
        end
      end
      default: begin
        state_nxt.st = QETL_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  // Every field resets to a constant; timing and lane fields reset to zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '{st: QETL_IDLE, ret: QETL_IDLE, opc: QETL_OPC_RST, etl: QETL_ETL_RST, brk: QETL_BRK_RST,
                   rdata: 32'h00000000, guard_cnt: QETL_CNT_RST, hold_cnt: 4'h0, csh_cnt: 5'h00,
                   qclk_sync: 2'h0, tick_sync: 2'h0, qclk_prev: 1'b0, tick_prev: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command outputs.

  // The instruction, its opcode and lane mode follow the issuing state.
  always_comb begin
    cmd_valid = 1'b1;
    cmd_has_addr = 1'b0;
    cmd_opcode = state_r.opc[QETL_OPC_ERS_LSB +: QETL_OPC_W];
    cmd_lane_mode = state_r.etl[QETL_ERS_LSB +: QETL_LANE_W];
    case (state_r.st)
      QETL_ERS: begin
        cmd_has_addr = 1'b1;
        cmd_opcode = state_r.opc[QETL_OPC_ERS_LSB +: QETL_OPC_W];
        cmd_lane_mode = state_r.etl[QETL_ERS_LSB +: QETL_LANE_W];
      end
      QETL_WEN: begin
        cmd_opcode = state_r.opc[QETL_OPC_WEN_LSB +: QETL_OPC_W];
        cmd_lane_mode = state_r.etl[QETL_WEN_LSB +: QETL_LANE_W];
      end
      QETL_SUS: begin
        cmd_opcode = state_r.opc[QETL_OPC_SUS_LSB +: QETL_OPC_W];
        cmd_lane_mode = state_r.etl[QETL_SUS_LSB +: QETL_LANE_W];
      end
      QETL_RES: begin
        cmd_opcode = state_r.opc[QETL_OPC_RES_LSB +: QETL_OPC_W];
        cmd_lane_mode = state_r.etl[QETL_RES_LSB +: QETL_LANE_W];
      end
      default: begin
        cmd_valid = 1'b0;
      end
    endcase
  end

  // The address lane mode is stable from the register, used while an address is sent.
  assign cmd_addr_lane_mode = state_r.etl[QETL_EAD_LSB +: QETL_LANE_W];
  assign cs_force_high = (state_r.st == QETL_CSH);
  assign seq_busy = (state_r.st != QETL_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // Burst break control.

  // Break only when leaving a continuous read in auto, instruction once mode.
  assign brk_request = state_r.brk[QETL_BRK_EN_BIT] & auto_mode & instruction_once_mode & prev_cmd_read
                       & next_cmd_nonread;
  assign break_word = state_r.brk[QETL_BRK_WRD_LSB +: QETL_BRK_WRD_W];
  assign break_two_bytes = state_r.brk[QETL_BRK_SZ_BIT];
  assign break_lane_mode = state_r.brk[QETL_BRK_MD_LSB +: QETL_LANE_W];

  // The low nibble is released only for an enabled two byte break.
  assign io_oe = io_drive_req & ~(brk_low_nibble & state_r.brk[QETL_SEC_HF_BIT] & state_r.brk[QETL_BRK_EN_BIT]
                                  & state_r.brk[QETL_BRK_SZ_BIT]);

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hold_wait_a: assert property ((state_r.st == QETL_HOLD && state_nxt.st != QETL_HOLD) |->
    (state_r.hold_cnt >= state_r.etl[QETL_HLD_LSB +: QETL_HLD_W] && !read_pending))
    else $error("Erase or resume left the idle hold too early.");

  guard_wait_a: assert property ((state_r.st == QETL_GUARD) ##1 (state_r.st == QETL_SUS) |->
    ($past(state_r.guard_cnt) >= state_r.etl[QETL_SGD_LSB +: QETL_SGD_W]))
    else $error("Suspend issued before the guard delay.");

  guard_restart_a: assert property (((state_r.st == QETL_ERS || state_r.st == QETL_RES) && cmd_done) |=>
    (state_r.guard_cnt == 6'h00 && state_r.st == QETL_CSH))
    else $error("Guard timer did not restart after erase or resume.");

  cs_high_a: assert property ((state_r.st == QETL_CSH && state_nxt.st != QETL_CSH) |->
    (state_r.csh_cnt >= state_r.etl[QETL_CSH_LSB +: QETL_CSH_W]))
    else $error("Chip select high time cut short.");

  addr_lane_a: assert property ((state_r.st == QETL_ERS) |->
    (cmd_has_addr && cmd_addr_lane_mode == state_r.etl[9:8]))
    else $error("Erase address lane mode wrong.");

  ers_lane_a: assert property ((state_r.st == QETL_ERS) |->
    (cmd_valid && cmd_lane_mode == state_r.etl[1:0]))
    else $error("Erase opcode lane mode wrong.");

  sus_lane_a: assert property ((state_r.st == QETL_SUS) |-> (cmd_lane_mode == state_r.etl[5:4]
    && cmd_opcode == state_r.opc[23:16]))
    else $error("Suspend lane mode or opcode wrong.");

  ers_opcode_a: assert property ((state_r.st == QETL_ERS) |-> (cmd_opcode == state_r.opc[7:0]))
    else $error("Erase opcode wrong.");

  nibble_off_a: assert property ((io_drive_req && brk_low_nibble && state_r.brk[20] && state_r.brk[16]
    && state_r.brk[17]) |-> !io_oe)
    else $error("Low nibble driven while released.");

  tristate_gate_a: assert property ((!state_r.brk[16] || !state_r.brk[17]) |-> (io_oe == io_drive_req))
    else $error("Tristate acted outside a two byte break.");

  reserved_zero_a: assert property ((state_r.etl[31:30] == 2'h0 && state_r.etl[23:20] == 4'h0
    && state_r.etl[15] == 1'b0 && state_r.brk[31:21] == 11'h000))
    else $error("Reserved bits not zero.");

endmodule

/* tb/qetl_flash_model.sv */
// Behavioural model of the serial shifter and flash behind the erase sequencer.
`timescale 1ns/1ps
module qetl_flash_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic cmd_valid,
  input wire logic cs_force_high,
  output logic cmd_done,
  output logic qspi_clk
);
  // Shift cycles spent on the current instruction.
  int cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // One done pulse per instruction, after a short or a long shift time.
  // The pulse is never repeated while the sequencer still shows the old request.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 0;
      cmd_done <= 1'b0;
    end else if (cmd_valid && !cmd_done && cnt_r >= (slow ? 12 : 1)) begin
      cnt_r <= 0;
      cmd_done <= 1'b1;
    end else begin
      cnt_r <= (cmd_valid && !cmd_done) ? cnt_r + 1 : 0;
      cmd_done <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus clock of 200 ns, unrelated in phase to pclk; it stands low between frames.
  initial begin
    qspi_clk = 1'b0;
    #37;
    forever begin
      #100;
      qspi_clk = (cmd_valid || cs_force_high) ? ~qspi_clk : 1'b0;
    end
  end
endmodule

/* tb/qetl_top_bench.sv */
// Self-checking bench for the erase timing and lane block.
`timescale 1ns/1ps
module qetl_top_bench
  import qetl_pkg::*;
  ;
  // Opcodes and timing fields used by the erase walk.
  localparam logic [31:0] OPC = 32'h7A7506D8;
  localparam logic [31:0] ETL = 32'h02050D92;
  localparam logic [31:0] RA [4] = '{QETL_OPC_ADDR, QETL_ETL_ADDR, QETL_BRK_ADDR, QETL_STS_ADDR};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr, qspi_clk_in, cmd_done, cmd_valid, cmd_has_addr, cs_force_high, seq_busy;
  logic tick_222k = 1'b0, slow = 1'b0;
  logic erase_req = 1'b0, suspend_req = 1'b0, resume_req = 1'b0, erase_done = 1'b0, read_pending = 1'b0;
  logic auto_mode = 1'b1, instruction_once_mode = 1'b1, prev_cmd_read = 1'b1, next_cmd_nonread = 1'b1;
  logic io_drive_req = 1'b1, brk_low_nibble = 1'b1, brk_request, break_two_bytes, io_oe;
  logic [7:0] cmd_opcode;
  logic [1:0] cmd_lane_mode, cmd_addr_lane_mode, break_lane_mode;
  logic [15:0] break_word;
  int failures = 0;
  int checked = 0;

  // 40 MHz bus clock and a free running 222 kHz timer clock.
  always #12.5 pclk = ~pclk;
  always #2252 tick_222k = ~tick_222k;

  qetl_top i_qetl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .qspi_clk_in(qspi_clk_in), .tick_222k(tick_222k), .erase_req(erase_req), .suspend_req(suspend_req),
    .resume_req(resume_req), .erase_done(erase_done), .read_pending(read_pending), .cmd_done(cmd_done),
    .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_lane_mode(cmd_lane_mode),
    .cmd_has_addr(cmd_has_addr), .cmd_addr_lane_mode(cmd_addr_lane_mode), .cs_force_high(cs_force_high),
    .seq_busy(seq_busy), .auto_mode(auto_mode), .instruction_once_mode(instruction_once_mode),
    .prev_cmd_read(prev_cmd_read), .next_cmd_nonread(next_cmd_nonread), .brk_request(brk_request),
    .break_word(break_word), .break_two_bytes(break_two_bytes), .break_lane_mode(break_lane_mode),
    .io_drive_req(io_drive_req), .brk_low_nibble(brk_low_nibble), .io_oe(io_oe));

  qetl_flash_model i_qetl_flash_model (.pclk(pclk), .presetn(presetn), .slow(slow), .cmd_valid(cmd_valid),
    .cs_force_high(cs_force_high), .cmd_done(cmd_done), .qspi_clk(qspi_clk_in));

  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the result.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    check(32'(pready), 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps psel from being lowered and raised again in one time step.
    @(posedge pclk);
  endtask

  // Waits for one instruction, checks it, then measures the chip select high time.
  task automatic do_cmd(input logic [7:0] opc, input logic [1:0] ln, input logic ha, output int cyc);
    int n;
    cyc = 0;
    n = 0;
    @(negedge pclk);
    while (cmd_valid !== 1'b1 && cyc < 3000) begin
      cyc++;
      @(negedge pclk);
    end
    check(32'(cmd_valid), 32'h1);
    check(32'(cmd_opcode), 32'(opc));
    check(32'(cmd_lane_mode), 32'(ln));
    check(32'(cmd_has_addr), 32'(ha));
    check(32'(cmd_addr_lane_mode), 32'h1);
    while (cs_force_high !== 1'b1 && n < 3000) begin
      n++;
      @(negedge pclk);
    end
    n = 0;
    while (cs_force_high === 1'b1 && n < 3000) begin
      n++;
      @(negedge pclk);
    end
    check(32'(n >= 16 && n < 3000), 32'h1);
    @(posedge pclk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence of tests.
  initial begin
    logic [31:0] rd;
    logic er;
    int cyc;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (RA[k]) begin
      apb(1'b0, RA[k], 32'h0, rd, er);
      check(rd, 32'h0);
    end
    // All ones except bit 11 and the lane fields, which get quad so no reserved encoding is ever written.
    apb(1'b1, QETL_ETL_ADDR, 32'hFFFFF6AA, rd, er);
    apb(1'b0, QETL_ETL_ADDR, 32'h0, rd, er);
    check(rd, 32'hFFFFF6AA & QETL_ETL_MASK);
    apb(1'b1, QETL_BRK_ADDR, 32'hFFFBFFFF, rd, er);
    apb(1'b0, QETL_BRK_ADDR, 32'h0, rd, er);
    check(rd, 32'hFFFBFFFF & QETL_BRK_MASK);
    apb(1'b1, 32'h0C000034, 32'hFFFFFFFF, rd, er);
    check(32'(er), 32'h1);
    apb(1'b0, 32'h0C000034, 32'h0, rd, er);
    check(rd, 32'h0);
    $display("Test registers done");
    // Erase walk: write enable, erase, guarded suspend, held resume.
    apb(1'b1, QETL_OPC_ADDR, OPC, rd, er);
    apb(1'b1, QETL_ETL_ADDR, ETL, rd, er);
    slow <= 1'b1;
    erase_req <= 1'b1;
    @(posedge pclk);
    erase_req <= 1'b0;
    do_cmd(8'h06, 2'h0, 1'b0, cyc);
    do_cmd(8'hD8, 2'h2, 1'b1, cyc);
    slow <= 1'b0;
    suspend_req <= 1'b1;
    @(posedge pclk);
    suspend_req <= 1'b0;
    do_cmd(8'h75, 2'h1, 1'b0, cyc);
    check(32'(cyc >= 120), 32'h1);
    apb(1'b0, QETL_STS_ADDR, 32'h0, rd, er);
    check(rd, 32'(QETL_SUSP));
    check(32'(seq_busy), 32'h1);
    read_pending <= 1'b1;
    resume_req <= 1'b1;
    @(posedge pclk);
    resume_req <= 1'b0;
    repeat (28) @(posedge pclk);
    @(negedge pclk);
    check(32'(cmd_valid), 32'h0);
    @(posedge pclk);
    read_pending <= 1'b0;
    do_cmd(8'h7A, 2'h2, 1'b0, cyc);
    check(32'(cyc >= 5 && cyc <= 8), 32'h1);
    erase_done <= 1'b1;
    @(posedge pclk);
    erase_done <= 1'b0;
    apb(1'b0, QETL_STS_ADDR, 32'h0, rd, er);
    check(rd, 32'(QETL_IDLE));
    check(32'(seq_busy), 32'h0);
    $display("Test erase sequence done");
    // Burst break: every combination of enable, size and tristate.
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, QETL_BRK_ADDR, 32'hA5C3 | (32'(i[0]) << 16) | (32'(i[1]) << 17) | (32'(i % 3) << 18)
          | (32'(i[2]) << 20), rd, er);
      @(negedge pclk);
      check(32'(io_oe), 32'(i != 7));
      check(32'(brk_request), 32'(i[0]));
      check(32'(break_two_bytes), 32'(i[1]));
      check(32'(break_word), 32'hA5C3);
      check(32'(break_lane_mode), 32'(i % 3));
      @(posedge pclk);
    end
    brk_low_nibble <= 1'b0;
    next_cmd_nonread <= 1'b0;
    @(negedge pclk);
    check(32'(io_oe), 32'h1);
    check(32'(brk_request), 32'h0);
    $display("Test burst break done");
    final_report();
  end

  // Watchdog against a hang; the tests need fewer than 1000 clock cycles.
  initial begin
    #400000;
    failures++;
    $display("FAIL at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
